// file: lpc_asserts.sv
/*
  port checker for lpc_top.
  bound to lpc_top from the testbench top file.
*/
`timescale 1ns/1ps
`default_nettype none
module lpc_asserts (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic [3:0] O_COM_EN,
  input wire logic [3:0] O_COM_SEL,
  input wire logic [3:0] O_COM_NONSEL,
  input wire logic [31:0] O_SEG_EN,
  input wire logic O_EXPANSION_EN,
  input wire logic O_BLANK,
  input wire logic O_RUN,
  input wire logic O_DRIVE_SUPPLY_ON,
  input wire logic O_FRAME_TICK,
  input wire logic [1:0] O_PHASE
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  // expected common enables
  function automatic logic [3:0] ecom(logic [7:0] d);
    return d[5] ? 4'hf : 4'hf >> (3 - d[7:6]);
  endfunction : ecom
  // expected segment enables
  function automatic logic [31:0] eseg(logic [7:0] d);
    if (d[4] || d[3:1] == 3'h0) return 32'h0;
    if (d[3]) return 32'hffffffff;
    return ~(32'hffffffff >> (8 * d[3:1]));
  endfunction : eseg
  // register writes followed by a live cycle
  sequence pc_wr;
    I_CE && I_WR && I_ADDR == lpc_pkg::ADDR_PORT_CTRL ##1 I_CE;
  endsequence
  sequence ct_wr;
    I_CE && I_WR && I_ADDR == lpc_pkg::ADDR_CTRL ##1 I_CE;
  endsequence
  com_en_a: assert property (pc_wr |=>
    O_COM_EN == ecom($past(I_WDATA, 2))) else $error("common enable wrong");
  sel_inside_a: assert property ((O_COM_SEL & ~O_COM_EN) == 4'h0)
    else $error("undriven common selected");
  nonsel_bit_a: assert property (O_COM_NONSEL[2:0] == 3'h0)
    else $error("low common forced non-selected");
  seg_en_a: assert property (pc_wr |=>
    O_SEG_EN == eseg($past(I_WDATA, 2))) else $error("segment enable wrong");
  exp_en_a: assert property (pc_wr |=> O_EXPANSION_EN ==
    (($past(I_WDATA, 2) & 8'h1f) == 8'h10)) else $error("expansion wrong");
  blank_out_a: assert property (ct_wr |=>
    O_BLANK == !$past(I_WDATA[4], 2)) else $error("blank wrong");
  run_out_a: assert property (ct_wr |=>
    O_RUN == $past(I_WDATA[5], 2)) else $error("run wrong");
  supply_out_a: assert property (ct_wr |=>
    O_DRIVE_SUPPLY_ON == $past(I_WDATA[6], 2)) else $error("supply wrong");
  halt_phase_a: assert property (!O_RUN [*3] |->
    O_PHASE == 2'h0 && !O_FRAME_TICK) else $error("halted but moving");
  fixed_bit_a: assert property (I_CE && I_RD &&
    I_ADDR == lpc_pkg::ADDR_CTRL |=> O_RDATA[7]) else $error("top bit low");
endmodule : lpc_asserts
`default_nettype wire

// file: lpc_divider.sv
/*
  frame clock divider: free counter, tick per selected ratio.
  assumes the subclock tick is already in the core clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module lpc_divider #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic i_sub_tick,
  input wire logic i_source_sys,
  input wire logic [2:0] i_div_sel,
  output logic o_tick
);
  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;
  logic [WIDTH-1:0] mask;

  // ----------------------------------------------------------------
  // ratio selection
  // ----------------------------------------------------------------
  // mask of low counter bits; all ones means a full period
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    mask = '0;
    if (i_source_sys) begin
      mask = WIDTH'((16'h0002 << i_div_sel) - 16'h0001);
      if (i_run) begin
        nxt_cnt = cnt_ff + 1'b1;
        nxt_tick = ((cnt_ff & mask) == mask);
      end
    end else begin
      // subclock /1, /2 or /4
      case (i_div_sel[1:0])
        2'h0: mask = '0;
        2'h1: mask = WIDTH'(1);
        default: mask = WIDTH'(3);
      endcase
      if (i_run && i_sub_tick) begin
        nxt_cnt = cnt_ff + 1'b1;
        nxt_tick = ((cnt_ff & mask) == mask);
      end
    end
  end

  // registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (i_ce) begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff;
endmodule : lpc_divider
`default_nettype wire

// file: lpc_panel.sv
/*
  panel model: measures spacing of frame ticks.
  assumes ticks are one core cycle wide.
*/
`timescale 1ns/1ps
`default_nettype none
module lpc_panel (
  input wire logic i_clk,
  input wire logic i_tick,
  output int o_gap,
  output int o_ticks
);
  int cnt = 0;
  int gap_q = 0;
  int ticks_q = 0;
  assign o_gap = gap_q;
  assign o_ticks = ticks_q;
  // cycles between two frame ticks
  always @(posedge i_clk) begin
    cnt <= i_tick ? 1 : cnt + 1;
    if (i_tick) begin
      gap_q <= cnt;
      ticks_q <= ticks_q + 1;
    end
  end
endmodule : lpc_panel
`default_nettype wire

// file: lpc_pkg.sv
/*
  constants for the segment lcd port and frame control block.
  assumes an 8-bit register port on the core clock.
*/
// What this block does
// - duty bits pick static, 1/2, 1/3, 1/4
// - static expand: commons four to two copy one
// - half duty expand: four copies three, two copies one
// - third duty expand: common four non-selected
// - group field sets top 8/16/24/32 segments
// - expansion bit with group field zero turns top four into expansion
// - frame clock: subclock /1,/2,/4 or system /2../256
// - display bit clear shows blank segments
// - run bit clear halts controller
// - supply bit switches drive supply
package lpc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_CTRL = 8'hc0;
  localparam logic [7:0] ADDR_CTRL = 8'hc1;
  localparam logic [7:0] RST_PORT_CTRL = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h80;
  localparam logic [7:0] CTRL_FIXED_MASK = 8'h80;
  // ----------------------------------------------------------------
  // port control fields
  // ----------------------------------------------------------------
  localparam int DUTY_POS = 6;
  localparam int COMMON_EXPAND_POS = 5;
  localparam int EXPANSION_PIN_SELECT_POS = 4;
  localparam int SEG_GROUP_POS = 0;
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int DRIVE_SUPPLY_ON_POS = 6;
  localparam int CONTROLLER_RUN_POS = 5;
  localparam int SHOW_RAM_DATA_POS = 4;
  localparam int FRAME_CLOCK_SOURCE_POS = 3;
  localparam int FRAME_DIVIDER_POS = 0;
  // duty codes
  localparam logic [1:0] DUTY_STATIC = 2'h0;
  localparam logic [1:0] DUTY_HALF = 2'h1;
  localparam logic [1:0] DUTY_THIRD = 2'h2;
  localparam logic [1:0] DUTY_QUARTER = 2'h3;
  localparam int SEG_COUNT = 32;
endpackage : lpc_pkg

// file: lpc_top.sv
/*
  lcd port control and frame control registers, common and segment
  pin function decode, frame phase generation.
  assumes a plain register port on I_CORE_CLK and a subclock pin.
*/
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module lpc_top (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_SUBCLK,
  output logic [7:0] O_RDATA,
  output logic [3:0] O_COM_EN,
  output logic [3:0] O_COM_SEL,
  output logic [3:0] O_COM_NONSEL,
  output logic [31:0] O_SEG_EN,
  output logic O_EXPANSION_EN,
  output logic O_BLANK,
  output logic O_RUN,
  output logic O_DRIVE_SUPPLY_ON,
  output logic O_FRAME_TICK,
  output logic [1:0] O_PHASE
);
  logic [7:0] port_ctrl_ff;
  logic [7:0] nxt_port_ctrl;
  logic [6:0] ctrl_ff;
  logic [6:0] nxt_ctrl;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic sub_s1_ff;
  logic sub_s2_ff;
  logic sub_s3_ff;
  logic sub_tick;
  logic frame_tick;
  logic [1:0] phase_ff;
  logic [1:0] nxt_phase;
  logic [3:0] com_en_ff;
  logic [3:0] nxt_com_en;
  logic [3:0] com_sel_ff;
  logic [3:0] nxt_com_sel;
  logic [3:0] com_nonsel_ff;
  logic [3:0] nxt_com_nonsel;
  logic [31:0] seg_en_ff;
  logic [31:0] nxt_seg_en;
  logic exp_en_ff;
  logic nxt_exp_en;
  logic blank_ff;
  logic run_ff;
  logic supply_ff;
  logic tick_ff;
  logic [1:0] duty;
  logic common_expand;
  logic expansion_pin_select;
  logic [3:0] segment_group_select;

  // number of top segment groups of four enabled by the group field
  function automatic logic [3:0] seg_groups(input logic [3:0] code);
    case (code[3:1])
      3'h0: seg_groups = 4'h0;
      3'h1: seg_groups = 4'h2;
      3'h2: seg_groups = 4'h4;
      3'h3: seg_groups = 4'h6;
      default: seg_groups = 4'h8;
    endcase
  endfunction : seg_groups

  assign duty = port_ctrl_ff[lpc_pkg::DUTY_POS +: 2];
  assign common_expand = port_ctrl_ff[lpc_pkg::COMMON_EXPAND_POS];
  assign expansion_pin_select =
    port_ctrl_ff[lpc_pkg::EXPANSION_PIN_SELECT_POS];
  assign segment_group_select = port_ctrl_ff[lpc_pkg::SEG_GROUP_POS +: 4];

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // writes and one-cycle-late read data
  always_comb begin
    nxt_port_ctrl = port_ctrl_ff;
    nxt_ctrl = ctrl_ff;
    nxt_rdata = 8'h00;
    if (I_WR && I_ADDR == lpc_pkg::ADDR_PORT_CTRL) begin
      nxt_port_ctrl = I_WDATA;
    end
    if (I_WR && I_ADDR == lpc_pkg::ADDR_CTRL) begin
      nxt_ctrl = I_WDATA[6:0];
    end
    if (I_RD) begin
      case (I_ADDR)
        lpc_pkg::ADDR_PORT_CTRL: nxt_rdata = port_ctrl_ff;
        lpc_pkg::ADDR_CTRL: nxt_rdata = lpc_pkg::CTRL_FIXED_MASK | {1'b0, ctrl_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      port_ctrl_ff <= lpc_pkg::RST_PORT_CTRL;
      ctrl_ff <= lpc_pkg::RST_CTRL[6:0];
      rdata_ff <= 8'h00;
    end else if (I_CE) begin
      port_ctrl_ff <= nxt_port_ctrl;
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // subclock synchroniser and edge
  // ----------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      sub_s1_ff <= 1'b0;
      sub_s2_ff <= 1'b0;
      sub_s3_ff <= 1'b0;
    end else if (I_CE) begin
      sub_s1_ff <= I_SUBCLK;
      sub_s2_ff <= sub_s1_ff;
      sub_s3_ff <= sub_s2_ff;
    end
  end
  assign sub_tick = sub_s2_ff & ~sub_s3_ff;

  // frame clock divider
  lpc_divider #(
    .WIDTH(8)
  ) u_div (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_run(ctrl_ff[lpc_pkg::CONTROLLER_RUN_POS]),
    .i_sub_tick(sub_tick),
    .i_source_sys(ctrl_ff[lpc_pkg::FRAME_CLOCK_SOURCE_POS]),
    .i_div_sel(ctrl_ff[lpc_pkg::FRAME_DIVIDER_POS +: 3]),
    .o_tick(frame_tick)
  );

  // ----------------------------------------------------------------
  // common phase and pin decode
  // ----------------------------------------------------------------
  always_comb begin
    nxt_phase = phase_ff;
    nxt_com_en = 4'h0;
    nxt_com_sel = 4'h0;
    nxt_com_nonsel = 4'h0;
    nxt_seg_en = 32'h0;
    nxt_exp_en = 1'b0;
    // phase steps once per frame tick, wraps at duty count
    if (!ctrl_ff[lpc_pkg::CONTROLLER_RUN_POS]) begin
      nxt_phase = 2'h0;
    end else if (frame_tick) begin
      nxt_phase = (phase_ff >= duty) ? 2'h0 : phase_ff + 2'h1;
    end
    case (duty)
      lpc_pkg::DUTY_STATIC: begin
        nxt_com_en = common_expand ? 4'hf : 4'h1;
        nxt_com_sel = common_expand ? 4'hf : 4'h1;
      end
      lpc_pkg::DUTY_HALF: begin
        nxt_com_en = common_expand ? 4'hf : 4'h3;
        nxt_com_sel[0] = (phase_ff == 2'h0);
        nxt_com_sel[1] = (phase_ff == 2'h1);
        if (common_expand) begin
          nxt_com_sel[2] = (phase_ff == 2'h1);
          nxt_com_sel[1] = (phase_ff == 2'h0);
          nxt_com_sel[3] = (phase_ff == 2'h1);
        end
      end
      lpc_pkg::DUTY_THIRD: begin
        nxt_com_en = common_expand ? 4'hf : 4'h7;
        nxt_com_sel[0] = (phase_ff == 2'h0);
        nxt_com_sel[1] = (phase_ff == 2'h1);
        nxt_com_sel[2] = (phase_ff == 2'h2);
        nxt_com_nonsel[3] = common_expand;
      end
      default: begin
        nxt_com_en = 4'hf;
        nxt_com_sel = 4'h1 << phase_ff;
      end
    endcase
    // segment groups, counted down from the top pin
    for (int g = 0; g < 8; g++) begin
      if (!expansion_pin_select &&
          (7 - g) < int'(seg_groups(segment_group_select))) begin
        nxt_seg_en[g*4 +: 4] = 4'hf;
      end
    end
    // expansion takes the top four pins when field is zero
    if (expansion_pin_select && segment_group_select == 4'h0) begin
      nxt_exp_en = 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      phase_ff <= 2'h0;
      com_en_ff <= 4'h0;
      com_sel_ff <= 4'h0;
      com_nonsel_ff <= 4'h0;
      seg_en_ff <= 32'h0;
      exp_en_ff <= 1'b0;
      blank_ff <= 1'b1;
      run_ff <= 1'b0;
      supply_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else if (I_CE) begin
      phase_ff <= nxt_phase;
      com_en_ff <= nxt_com_en;
      com_sel_ff <= nxt_com_sel;
      com_nonsel_ff <= nxt_com_nonsel;
      seg_en_ff <= nxt_seg_en;
      exp_en_ff <= nxt_exp_en;
      blank_ff <= ~ctrl_ff[lpc_pkg::SHOW_RAM_DATA_POS];
      run_ff <= ctrl_ff[lpc_pkg::CONTROLLER_RUN_POS];
      supply_ff <= ctrl_ff[lpc_pkg::DRIVE_SUPPLY_ON_POS];
      tick_ff <= frame_tick;
    end
  end

  // outputs straight from flip-flops
  assign O_RDATA = rdata_ff;
  assign O_COM_EN = com_en_ff;
  assign O_COM_SEL = com_sel_ff;
  assign O_COM_NONSEL = com_nonsel_ff;
  assign O_SEG_EN = seg_en_ff;
  assign O_EXPANSION_EN = exp_en_ff;
  assign O_BLANK = blank_ff;
  assign O_RUN = run_ff;
  assign O_DRIVE_SUPPLY_ON = supply_ff;
  assign O_FRAME_TICK = tick_ff;
  assign O_PHASE = phase_ff;
endmodule : lpc_top
`default_nettype wire

// file: tb_lcd_port_and_frame_control.sv
/*
  testbench for lpc_top with panel model.
  assumes lpc_asserts and lpc_panel compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_port_and_frame_control;
  localparam logic [7:0] PC = lpc_pkg::ADDR_PORT_CTRL;
  localparam logic [7:0] CT = lpc_pkg::ADDR_CTRL;
  logic clk = 0, rst, ce, wr, rd, subclk;
  logic [7:0] addr, wdata, rdata, v;
  logic [3:0] com_en, com_sel, com_nonsel;
  logic [31:0] seg_en, e;
  logic exp_en, blank, run, supply, tick;
  logic [1:0] phase;
  logic [3:0] sc = 0;
  int gap, ticks, bad_count = 0, tests_run = 0, i, j;
  always #12.5 clk = ~clk;
  // subclock, period 16 core cycles
  always @(posedge clk) sc <= sc + 4'h1;
  assign subclk = sc[3];
  lpc_top lpc_top_i (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(ce),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .I_SUBCLK(subclk), .O_RDATA(rdata), .O_COM_EN(com_en),
    .O_COM_SEL(com_sel), .O_COM_NONSEL(com_nonsel), .O_SEG_EN(seg_en),
    .O_EXPANSION_EN(exp_en), .O_BLANK(blank), .O_RUN(run),
    .O_DRIVE_SUPPLY_ON(supply), .O_FRAME_TICK(tick), .O_PHASE(phase));
  lpc_panel lpc_panel_i (.i_clk(clk), .i_tick(tick), .o_gap(gap),
    .o_ticks(ticks));
  // verdict and end of run
  task automatic end_of_test();
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  // one-cycle register bus transfers
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrt
  task automatic rdt(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rdt
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  // bounded wait for frame ticks
  task automatic wait_ticks(input int n);
    int t0, k;
    t0 = ticks;
    for (k = 0; k < 3000 && ticks < t0 + n; k++) @(posedge clk);
    if (ticks < t0 + n) begin
      bad_count++;
      $display("CHECK FAILED at %0t: no frame tick", $time);
      end_of_test();
    end
  endtask : wait_ticks
  initial begin
    {rst, ce, addr, wdata, wr, rd} = {1'b1, 1'b1, 18'h0};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdt(PC, v); chk(v, 8'h00);
    rdt(CT, v); chk(v, 8'h80);
    wrt(CT, 8'h00); rdt(CT, v); chk(v, 8'h80);
    rdt(8'h55, v); chk(v, 8'h00);
    // clock enable low: a write is ignored, state frozen
    @(posedge clk);
    ce <= 1'b0;
    wrt(PC, 8'hff);
    ce <= 1'b1;
    rdt(PC, v); chk(v, 8'h00);
    wrt(CT, 8'h78); rdt(CT, v); chk(v, 8'hf8);
    chk({blank, run, supply}, 3'h3);
    // duty and common expand modes, frame running
    for (i = 0; i < 8; i++) begin
      wrt(PC, {i[2:0], 5'h00}); settle();
      chk(com_en, i[0] ? 4'hf : 4'hf >> (3 - i[2:1]));
      for (j = 0; j < 12; j++) begin
        @(posedge clk); #1;
        if (i == 1) chk(com_sel[3:1], {3{com_sel[0]}});
        if (i == 3) chk({com_sel[3], com_sel[1]}, com_sel[2:1] & 2'h2 | {1'b0, com_sel[0]});
        if (i == 5) chk(com_nonsel[3], 1'b1);
      end
    end
    // every segment group code, then expansion pins
    for (i = 0; i < 16; i++) begin
      wrt(PC, i[7:0]); settle();
      e = i[3] ? 32'hffffffff : ~(32'hffffffff >> (8 * i[3:1]));
      chk(seg_en, i[3:1] == 3'h0 ? 32'h0 : e);
      chk(exp_en, 1'b0);
    end
    wrt(PC, 8'h10); settle();
    chk(exp_en, 1'b1);
    chk(seg_en, 32'h0);
    // frame clock: system /2../256, subclock /1,/2,/4,/4
    for (i = 0; i < 12; i++) begin
      wrt(CT, i < 8 ? 8'h68 | i[7:0] : 8'h60 | (i[7:0] - 8'h08));
      wait_ticks(3);
      chk(gap, i < 8 ? 2 << i : 16 << (i > 9 ? 2 : i - 8));
    end
    wrt(CT, 8'h40); settle(); repeat (3) @(posedge clk);
    chk({run, phase, blank}, 4'h1);
    // second reset with the controller halted
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdt(CT, v); chk(v, 8'h80);
    rdt(PC, v); chk(v, 8'h00);
    end_of_test();
  end
endmodule : tb_lcd_port_and_frame_control
bind lpc_top lpc_asserts lpc_asserts_i (.*);
`default_nettype wire
